/* File: verilog/lcdp_shared_ports.sv */
// top of the three lcd-shared input-only ports with their register file
// assumes a cpu master on the plain register port and pad cells outside
`timescale 1ns/1ps
module lcdp_shared_ports #(
	parameter bit HAS_PIN7 = 1'b1
) (
	input wire logic clock,
	input wire logic rstn,
	input wire lcdp_pkg::lcdp_req_s req,
	input wire lcdp_pkg::lcdp_bitop_s bitop,
	output logic [7:0] rdata,
	input wire logic [31:0] seg_drive,
	input wire logic [2:0][7:0] pad_in,
	output logic [2:0][7:0] pad_out,
	output logic [2:0][7:0] pad_oe_n,
	output logic [2:0][7:0] port_latch,
	output logic [2:0][7:0] port_direction,
	output logic [7:0] segment_pin_enable
);
	import lcdp_pkg::*;

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	// the pin maps are fixed, so only the package option may vary
	if (LCDP_NPORTS != 3) begin : g_bad_ports
		$error("lcdp_shared_ports serves exactly three ports");
	end
	if (LCDP_NSEGS != 32) begin : g_bad_segs
		$error("lcdp_shared_ports expects a 32-line segment bus");
	end

	// ****************************************************************
	// state
	// ****************************************************************
	lcdp_state_s q;
	lcdp_state_s d;

	// digital levels after the pin multiplexers
	logic [2:0][7:0] digital_in;

	// decoded selects for the bus request and the bit operation
	lcdp_sel_e rd_sel;
	lcdp_sel_e wr_sel;
	lcdp_sel_e bit_sel;

	// value and target of the write phase of this cycle
	lcdp_sel_e apply_sel;
	logic [7:0] apply_val;
	logic apply_en;

	// value seen by the read phase of a bit operation
	logic [7:0] bit_old;
	logic [7:0] bit_mask;

	// ****************************************************************
	// pin multiplexers
	// ****************************************************************
	// input-only pins, segment or digital input
	for (genvar p = 0; p < 3; p++) begin : g_port
		lcdp_pin_mux #(
			.PORT(p),
			.HAS_PIN7(HAS_PIN7)
		) u_mux (
			.seg_en(q.seg_en),
			.seg_drive(seg_drive),
			.pad_in(pad_in[p]),
			.pad_out(pad_out[p]),
			.pad_oe_n(pad_oe_n[p]),
			.digital_in(digital_in[p])
		);
	end

	// ****************************************************************
	// read side
	// ****************************************************************
	// current value of a register as the cpu sees it
	function automatic logic [7:0] reg_value(
		input lcdp_sel_e sel,
		input lcdp_state_s s,
		input logic [2:0][7:0] din
	);
		logic [7:0] v;
		unique case (sel)
			LCDP_SEL_E_DATA: v = din[LCDP_PORT_E];
			LCDP_SEL_F_DATA: v = din[LCDP_PORT_F];
			LCDP_SEL_G_DATA: v = din[LCDP_PORT_G];
			LCDP_SEL_E_DIR: v = s.dir[LCDP_PORT_E];
			LCDP_SEL_F_DIR: v = s.dir[LCDP_PORT_F];
			LCDP_SEL_G_DIR: v = s.dir[LCDP_PORT_G];
			LCDP_SEL_SEG_EN: v = s.seg_en;
			LCDP_SEL_NONE: v = LCDP_READ_ZERO;
		endcase
		return v;
	endfunction

	// address decode of both requesters
	always_comb begin
		rd_sel = lcdp_decode(req.addr);
		wr_sel = lcdp_decode(req.addr);
		bit_sel = lcdp_decode(bitop.addr);
	end

	// ****************************************************************
	// write side
	// ****************************************************************
	// a plain write wins if the master ever overlaps it with a bit operation
	always_comb begin
		bit_mask = 8'h01 << bitop.bit_sel;
		bit_old = reg_value(bit_sel, q, digital_in);
		apply_en = 1'b0;
		apply_sel = LCDP_SEL_NONE;
		apply_val = LCDP_READ_ZERO;
		if (req.wr) begin
			// full write replaces every bit read
			apply_en = 1'b1;
			apply_sel = wr_sel;
			apply_val = req.wdata;
		end else if (bitop.op) begin
			// register read (pin levels for a data port), one bit changed, all written
			apply_en = 1'b1;
			apply_sel = bit_sel;
			apply_val = bitop.set ? (bit_old | bit_mask) : (bit_old & ~bit_mask);
		end
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = q;
		// read data stands for one cycle only
		d.rdata = LCDP_READ_ZERO;
		if (req.rd) begin
			d.rdata = reg_value(rd_sel, q, digital_in);
		end
		if (apply_en) begin
			unique case (apply_sel)
				LCDP_SEL_E_DATA: d.latch[LCDP_PORT_E] = apply_val;
				LCDP_SEL_F_DATA: d.latch[LCDP_PORT_F] = apply_val;
				LCDP_SEL_G_DATA: d.latch[LCDP_PORT_G] = apply_val;
				LCDP_SEL_E_DIR: d.dir[LCDP_PORT_E] = apply_val;
				LCDP_SEL_F_DIR: d.dir[LCDP_PORT_F] = apply_val;
				LCDP_SEL_G_DIR: d.dir[LCDP_PORT_G] = apply_val;
				// single enable shared by all ports
				LCDP_SEL_SEG_EN: d.seg_en = apply_val;
				// unmapped writes are dropped silently
				LCDP_SEL_NONE: d.seg_en = q.seg_en;
			endcase
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	// one reset level covers power-on and all other resets alike
	always_ff @(posedge clock) begin
		if (!rstn) begin
			q.seg_en <= LCDP_RST_SEG_EN;
			q.latch <= {LCDP_RST_DATA, LCDP_RST_DATA, LCDP_RST_DATA};
			q.dir <= {LCDP_RST_DIR, LCDP_RST_DIR, LCDP_RST_DIR};
			q.rdata <= LCDP_READ_ZERO;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// the latches drive no pad: these ports have no output driver, so the
	// latch contents are only visible here for observation; direction also reads back through its register
	assign rdata = q.rdata;
	assign port_latch = q.latch;
	assign port_direction = q.dir;
	assign segment_pin_enable = q.seg_en;

endmodule

/* File: verilog/lcdp_pkg.sv */
// constants, types and helper functions for the lcd shared input ports
// assumes a single clock domain and an lcd driver that supplies segment levels
package lcdp_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int unsigned LCDP_ADDR_W = 9;
	localparam logic [8:0] LCDP_OFS_E_DATA = 9'h009;
	localparam logic [8:0] LCDP_OFS_E_DIR = 9'h089;
	localparam logic [8:0] LCDP_OFS_F_DATA = 9'h107;
	localparam logic [8:0] LCDP_OFS_G_DATA = 9'h108;
	localparam logic [8:0] LCDP_OFS_SEG_EN = 9'h10D;
	localparam logic [8:0] LCDP_OFS_F_DIR = 9'h187;
	localparam logic [8:0] LCDP_OFS_G_DIR = 9'h188;

	// values after any reset
	localparam logic [7:0] LCDP_RST_DATA = 8'h00;
	localparam logic [7:0] LCDP_RST_DIR = 8'hFF;
	localparam logic [7:0] LCDP_RST_SEG_EN = 8'hFF;
	localparam logic [7:0] LCDP_READ_ZERO = 8'h00;

	// ****************************************************************
	// segment-enable field positions and port indices
	// ****************************************************************
	localparam logic [2:0] LCDP_SEG_EN_GROUP_0_4 = 3'h0;
	localparam logic [2:0] LCDP_SEG_EN_GROUP_5_8 = 3'h1;
	localparam logic [2:0] LCDP_SEG_EN_GROUP_9_11 = 3'h2;
	localparam logic [2:0] LCDP_SEG_EN_GROUP_12_15 = 3'h3;
	localparam logic [2:0] LCDP_SEG_EN_GROUP_16_19 = 3'h4;
	localparam logic [2:0] LCDP_SEG_EN_GROUP_20_26 = 3'h5;
	localparam logic [2:0] LCDP_SEG_EN_GROUP_27_28 = 3'h6;
	localparam logic [2:0] LCDP_SEG_EN_GROUP_29_31 = 3'h7;

	localparam int unsigned LCDP_PORT_E = 0;
	localparam int unsigned LCDP_PORT_F = 1;
	localparam int unsigned LCDP_PORT_G = 2;
	localparam int unsigned LCDP_NPORTS = 3;
	localparam int unsigned LCDP_NSEGS = 32;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		LCDP_SEL_NONE,
		LCDP_SEL_E_DATA,
		LCDP_SEL_E_DIR,
		LCDP_SEL_F_DATA,
		LCDP_SEL_F_DIR,
		LCDP_SEL_G_DATA,
		LCDP_SEL_G_DIR,
		LCDP_SEL_SEG_EN
	} lcdp_sel_e;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lcdp_req_s;

	typedef struct packed {
		logic op;
		logic set;
		logic [2:0] bit_sel;
		logic [8:0] addr;
	} lcdp_bitop_s;

	typedef struct packed {
		logic [7:0] seg_en;
		logic [2:0][7:0] latch;
		logic [2:0][7:0] dir;
		logic [7:0] rdata;
	} lcdp_state_s;

	// ****************************************************************
	// functions
	// ****************************************************************
	function automatic lcdp_sel_e lcdp_decode(input logic [8:0] addr);
		lcdp_sel_e s;
		unique case (addr)
			LCDP_OFS_E_DATA: s = LCDP_SEL_E_DATA;
			LCDP_OFS_E_DIR: s = LCDP_SEL_E_DIR;
			LCDP_OFS_F_DATA: s = LCDP_SEL_F_DATA;
			LCDP_OFS_F_DIR: s = LCDP_SEL_F_DIR;
			LCDP_OFS_G_DATA: s = LCDP_SEL_G_DATA;
			LCDP_OFS_G_DIR: s = LCDP_SEL_G_DIR;
			LCDP_OFS_SEG_EN: s = LCDP_SEL_SEG_EN;
			default: s = LCDP_SEL_NONE;
		endcase
		return s;
	endfunction

	// segment line driven by a given port bit
	function automatic logic [4:0] lcdp_seg_of(input int unsigned port, input int unsigned b);
		logic [4:0] s;
		logic [4:0] bb;
		bb = 5'(b);
		if (port == LCDP_PORT_E) begin
			s = (b == 7) ? 5'h1B : 5'h05 + bb;
		end else if (port == LCDP_PORT_F) begin
			s = 5'h0C + bb;
		end else begin
			s = (b == 7) ? 5'h1C : 5'h14 + bb;
		end
		return s;
	endfunction

	// segment-enable bit covering a given port bit
	function automatic logic [2:0] lcdp_grp_of(input int unsigned port, input int unsigned b);
		logic [2:0] g;
		if (port == LCDP_PORT_E) begin
			g = (b < 4) ? LCDP_SEG_EN_GROUP_5_8 : (b < 7) ? LCDP_SEG_EN_GROUP_9_11 : LCDP_SEG_EN_GROUP_27_28;
		end else if (port == LCDP_PORT_F) begin
			g = (b < 4) ? LCDP_SEG_EN_GROUP_12_15 : LCDP_SEG_EN_GROUP_16_19;
		end else begin
			g = (b < 7) ? LCDP_SEG_EN_GROUP_20_26 : LCDP_SEG_EN_GROUP_27_28;
		end
		return g;
	endfunction

endpackage

/* File: verilog/lcdp_pin_mux.sv */
// per-port pin multiplexer between lcd segment drive and digital input
// assumes pad levels are synchronous to the clock and segment levels come from the lcd driver
`timescale 1ns/1ps
module lcdp_pin_mux #(
	parameter int unsigned PORT = 0,
	parameter bit HAS_PIN7 = 1'b1
) (
	input wire logic [7:0] seg_en,
	input wire logic [31:0] seg_drive,
	input wire logic [7:0] pad_in,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe_n,
	output logic [7:0] digital_in
);
	import lcdp_pkg::*;

	// ****************************************************************
	// one slice per pin
	// ****************************************************************
	for (genvar b = 0; b < 8; b++) begin : g_pin
		localparam logic [4:0] SEG = lcdp_seg_of(PORT, b);
		localparam logic [2:0] GRP = lcdp_grp_of(PORT, b);
		// bit 7 of the first and third port is missing in the small package
		localparam bit PRESENT = HAS_PIN7 || (b != 7) || (PORT == LCDP_PORT_F);
		logic seg_mode;
		assign seg_mode = seg_en[GRP] && PRESENT;
		assign pad_out[b] = seg_mode ? seg_drive[SEG] : 1'b0;
		assign pad_oe_n[b] = ~seg_mode;
		// digital only while group bit clear
		assign digital_in[b] = (!seg_mode && PRESENT) ? pad_in[b] : 1'b0;
	end
endmodule

/* File: bench/lcdp_pad_model.sv */
// pads and lcd driver seen from outside the shared input ports
// assumes the bench gives the outside level of every released pin
`timescale 1ns/1ps
module lcdp_pad_model (
	input wire logic clock,
	input wire logic [2:0][7:0] ext_level,
	input wire logic [2:0][7:0] pad_out,
	input wire logic [2:0][7:0] pad_oe_n,
	output logic [2:0][7:0] pad_in,
	output logic [31:0] seg_drive
);
	// a driven pin shows its segment level, a released one the outside level
	assign pad_in = (pad_oe_n & ext_level) | (~pad_oe_n & pad_out);
	// segment levels move every cycle so a wrong segment index shows
	initial seg_drive = 32'h9A3C5E71;
	always @(posedge clock) begin
		seg_drive <= {seg_drive[30:0], seg_drive[31] ^ seg_drive[21]};
	end
endmodule

/* File: bench/lcdp_monitor.sv */
// checker on the top ports of the lcd shared input ports
// assumes the bind at the foot attaches it to the top module
`timescale 1ns/1ps
module lcdp_monitor #(
	parameter bit HAS_PIN7 = 1'b1
) (
	input wire logic clock,
	input wire logic rstn,
	input wire lcdp_pkg::lcdp_req_s req,
	input wire lcdp_pkg::lcdp_bitop_s bitop,
	input wire logic [7:0] rdata,
	input wire logic [31:0] seg_drive,
	input wire logic [2:0][7:0] pad_in,
	input wire logic [2:0][7:0] pad_out,
	input wire logic [2:0][7:0] pad_oe_n,
	input wire logic [2:0][7:0] port_latch,
	input wire logic [2:0][7:0] port_direction,
	input wire logic [7:0] segment_pin_enable
);
	import lcdp_pkg::*;
	logic [7:0] se;
	logic [7:0] e_m;
	logic [7:0] f_m;
	logic [7:0] g_m;
	logic [7:0] f_dig;
	logic [7:0] f_rmw;
	// segment masks per pin; absent pins never count as segment pins
	assign se = segment_pin_enable;
	assign e_m = {HAS_PIN7 & se[6], {3{se[2]}}, {4{se[1]}}};
	assign f_m = {{4{se[4]}}, {4{se[3]}}};
	assign g_m = {HAS_PIN7 & se[6], {7{se[5]}}};
	// bit set or clear works on pin levels, not on the latch
	assign f_dig = pad_in[1] & ~f_m;
	assign f_rmw = bitop.set ? f_dig | (8'h01 << bitop.bit_sel) : f_dig & ~(8'h01 << bitop.bit_sel);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	a_reset_values: assert property (disable iff (1'b0) !rstn |=> se == 8'hFF && port_direction == '1)
		else $error("reset values wrong");
	a_rdata_idle: assert property (!req.rd |=> rdata == 8'h00)
		else $error("read data without a read");
	a_read_pins: assert property (req.rd && req.addr == LCDP_OFS_F_DATA |=> rdata == $past(f_dig))
		else $error("port read is not the pin levels");
	a_write_latch: assert property (req.wr && req.addr == LCDP_OFS_G_DATA |=> port_latch[2] == $past(req.wdata))
		else $error("latch write lost");
	a_enable_write: assert property (req.wr && req.addr == LCDP_OFS_SEG_EN |=> se == $past(req.wdata))
		else $error("segment enable write lost");
	a_bitop_rmw: assert property (bitop.op && !req.wr && bitop.addr == LCDP_OFS_F_DATA |=> port_latch[1] == $past(f_rmw))
		else $error("bit operation result wrong");
	a_oe_second: assert property (pad_oe_n[1] == ~f_m)
		else $error("second port drive enable wrong");
	a_map_second: assert property (pad_out[1] == (seg_drive[19:12] & f_m))
		else $error("second port segment map wrong");
	a_map_third: assert property (pad_out[2] == ({seg_drive[28], seg_drive[26:20]} & g_m) && pad_oe_n[2] == ~g_m)
		else $error("third port segment map wrong");
	a_map_first: assert property (pad_out[0] == ({seg_drive[27], seg_drive[11:5]} & e_m) && pad_oe_n[0] == ~e_m)
		else $error("first port segment map wrong");
	// main scenarios reached
	c_bitop: cover property (bitop.op);
	c_read_f: cover property (req.rd && req.addr == LCDP_OFS_F_DATA);
	c_all_digital: cover property (se == 8'h00);
endmodule

bind lcdp_shared_ports lcdp_monitor #(.HAS_PIN7(HAS_PIN7)) i_mon (.clock(clock), .rstn(rstn), .req(req),
	.bitop(bitop), .rdata(rdata), .seg_drive(seg_drive), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
	.port_latch(port_latch), .port_direction(port_direction), .segment_pin_enable(segment_pin_enable));

/* File: bench/tb_top.sv */
// self-checking bench for the lcd shared input ports
// assumes the pad model stands for the pins and the lcd driver
`timescale 1ns/1ps
module tb_top;
	import lcdp_pkg::*;
	typedef struct packed {
		logic [7:0] seg;
		logic [2:0][7:0] ext;
		logic [2:0][7:0] exp;
	} lcdp_row_s;
	logic clock;
	logic rstn;
	lcdp_req_s req;
	lcdp_bitop_s bitop;
	logic [7:0] rdata;
	logic [31:0] seg_drive;
	logic [2:0][7:0] ext_level;
	logic [2:0][7:0] pad_in;
	logic [2:0][7:0] pad_out;
	logic [2:0][7:0] pad_oe_n;
	logic [2:0][7:0] port_latch;
	logic [2:0][7:0] port_direction;
	logic [7:0] segment_pin_enable;
	logic [7:0] rdata_small;
	logic [2:0][7:0] oe_small;
	logic [7:0] v;
	int num_errors = 0;
	int n_compared = 0;
	logic [8:0] da [3] = '{LCDP_OFS_E_DATA, LCDP_OFS_F_DATA, LCDP_OFS_G_DATA};
	logic [8:0] ra [8] = '{LCDP_OFS_E_DATA, LCDP_OFS_E_DIR, LCDP_OFS_F_DATA, LCDP_OFS_G_DATA,
		LCDP_OFS_SEG_EN, LCDP_OFS_F_DIR, LCDP_OFS_G_DIR, 9'h0AA};
	logic [7:0] rv [8] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};
	// enable value, outside levels {third, second, first}, reads expected
	lcdp_row_s rows [5] = '{
		'{8'hFF, 24'hFFFFFF, 24'h000000},
		'{8'h00, 24'h813CA5, 24'h813CA5},
		'{8'h18, 24'h7EFF5A, 24'h7E005A},
		'{8'h60, 24'hFFFFFF, 24'h00FF7F},
		'{8'h06, 24'hFFC3FF, 24'hFFC380}
	};
	lcdp_shared_ports #(.HAS_PIN7(1'b1)) i_dut (.clock(clock), .rstn(rstn), .req(req), .bitop(bitop), .rdata(rdata),
		.seg_drive(seg_drive), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .port_latch(port_latch),
		.port_direction(port_direction), .segment_pin_enable(segment_pin_enable));
	lcdp_pad_model i_pads (.clock(clock), .ext_level(ext_level), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.pad_in(pad_in), .seg_drive(seg_drive));
	// small package option: bit 7 of the first and third port is absent, pins read the outside level directly
	lcdp_shared_ports #(.HAS_PIN7(1'b0)) i_dut_small (.clock(clock), .rstn(rstn), .req(req), .bitop(bitop),
		.rdata(rdata_small), .seg_drive(seg_drive), .pad_in(ext_level), .pad_out(), .pad_oe_n(oe_small),
		.port_latch(), .port_direction(), .segment_pin_enable());
	// 250 MHz clock
	always #2 clock = ~clock;
	// bus cycles; the trailing delay lets the edge's updates land
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		req.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge clock);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic bop(input logic s, input logic [2:0] b, input logic [8:0] a);
		@(posedge clock);
		bitop <= '{op: 1'b1, set: s, bit_sel: b, addr: a};
		@(posedge clock);
		bitop.op <= 1'b0;
		#1;
	endtask
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#8000;
		num_errors++;
		give_verdict();
	end
	// main sequence
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		req = '0;
		bitop = '0;
		ext_level = '1;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(ra[i], v);
			chk(v, rv[i]);
		end
		chk(port_latch, 24'h000000);
		chk(oe_small, 24'h800080);
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			@(posedge clock) ext_level <= rows[i].ext;
			wr(LCDP_OFS_SEG_EN, rows[i].seg);
			for (int j = 0; j < 3; j++) begin
				rd(da[j], v);
				chk(v, rows[i].exp[j]);
			end
		end
		$display("table test done");
		wr(LCDP_OFS_SEG_EN, 8'h00);
		@(posedge clock) ext_level <= 24'hB30F80;
		wr(LCDP_OFS_G_DATA, 8'h5C);
		chk(port_latch[2], 8'h5C);
		rd(LCDP_OFS_G_DATA, v);
		chk(v, 8'hB3);
		chk(rdata_small, 8'h33);
		$display("latch test done");
		wr(LCDP_OFS_SEG_EN, 8'h18);
		wr(LCDP_OFS_F_DIR, 8'h00);
		chk(pad_oe_n[1], 8'h00);
		rd(LCDP_OFS_F_DIR, v);
		chk(v, 8'h00);
		$display("direction test done");
		wr(LCDP_OFS_SEG_EN, 8'h00);
		bop(1'b1, 3'h6, LCDP_OFS_F_DATA);
		chk(port_latch[1], 8'h4F);
		bop(1'b0, 3'h0, LCDP_OFS_F_DATA);
		chk(port_latch[1], 8'h0E);
		wr(LCDP_OFS_F_DATA, 8'hA5);
		chk(port_latch[1], 8'hA5);
		bop(1'b1, 3'h7, LCDP_OFS_F_DIR);
		chk(port_direction[1], 8'h80);
		$display("bit operation test done");
		@(posedge clock) rstn <= 1'b0;
		@(posedge clock) rstn <= 1'b1;
		#1;
		chk(segment_pin_enable, 8'hFF);
		chk(port_direction, 24'hFFFFFF);
		$display("second reset test done");
		give_verdict();
	end
endmodule
